// ### src/rbs_pkg.sv
// Purpose: Shared constants of the reset boot sequencer.
// Assumes: One 25 MHz core clock; image sources are probed by engines
//          outside this block that answer with done and signature flags.
// Notes: Every offset, named reset value and cycle count lives here once.
package rbs_pkg;

    // Core clock rate and the settling interval before the jump.
    localparam int CLK_HZ = 25000000;
    localparam int SETTLE_MS = 200;
    localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 23;

    // Reset vector and memory map select value after reset.
    localparam logic [23:0] RESET_VECTOR = 24'hFFFF00;
    localparam logic MEM_MAP_SEL_RST = 1'h0;

    // Peripheral clock gate vector; a set bit means the clock is off.
    localparam int PCLK_W = 8;
    localparam logic [PCLK_W-1:0] PCLK_ALL_OFF = 8'hFF;
    localparam logic [2:0] PCLK_EMIF = 3'h0;
    localparam logic [2:0] PCLK_SPI = 3'h1;
    localparam logic [2:0] PCLK_I2C = 3'h2;
    localparam logic [2:0] PCLK_MMC = 3'h3;
    localparam logic [2:0] PCLK_USB = 3'h4;

    // Idle domain bits; bit 0 is the CPU domain, which is never idled.
    localparam logic [3:0] IDLE_NONE = 4'h0;
    localparam logic [3:0] IDLE_ALL_BUT_CPU = 4'hE;

    // Boot source codes presented to the probe engines.
    localparam logic [2:0] SRC_NOR = 3'h0;
    localparam logic [2:0] SRC_NAND = 3'h1;
    localparam logic [2:0] SRC_SPI = 3'h2;
    localparam logic [2:0] SRC_I2C = 3'h3;
    localparam logic [2:0] SRC_MMC = 3'h4;
    localparam logic [2:0] SRC_USB = 3'h5;

    // Probe steps in priority order.
    localparam logic [3:0] STEP_FIRST = 4'h0;
    localparam logic [3:0] STEP_LAST_SCAN = 4'h7;
    localparam logic [3:0] STEP_USB = 4'h8;

    // Probe parameters: access width, SPI chip select, clock rates.
    localparam logic [4:0] NOR_ACCESS_BITS = 5'h10;
    localparam logic [4:0] NAND_ACCESS_BITS = 5'h08;
    localparam logic [1:0] SPI_CHIP_SELECT = 2'h0;
    localparam int SPI_RATE_KHZ = 500;
    localparam logic [2:0] BUS_MODE_A = 3'h5;
    localparam logic [2:0] BUS_MODE_B = 3'h6;
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h50;
    localparam int I2C_RATE_KHZ = 400;
    localparam logic [1:0] SIG_BYTES = 2'h2;

    // PLL settings: reset state is powered down and bypassed.
    localparam logic [11:0] PLL_MULT_RST = 12'h000;
    localparam logic [11:0] PLL_MULT_375X = 12'h2ED;
    localparam logic [11:0] PLL_MULT_3X = 12'h005;
    localparam logic [11:0] PLL_MULT_1125X = 12'h8C9;
    localparam logic [1:0] PLL_FRAC_BOOT = 2'h0;
    localparam logic [4:0] PLL_OUT_DIV_BOOT = 5'h00;

    // Clock output pin state after reset.
    localparam logic CLOCK_OUTPUT_PIN_EN_RST = 1'h1;

endpackage

// ### src/rbs_ctl_if.sv
// Purpose: Carries gate and timer control between sequencer parts.
// Assumes: All members are synchronous to the core clock.
// Notes: The sequencer drives requests; helpers answer.
`timescale 1ns/100ps
interface rbs_ctl_if;
    logic [2:0] gate_sel;
    logic gate_on;
    logic tmr_start;
    logic tmr_expired;

    modport seq (output gate_sel, output gate_on, output tmr_start,
                 input tmr_expired);
    modport gate (input gate_sel, input gate_on);
    modport tmr (input tmr_start, output tmr_expired);
endinterface

// ### src/rbs_settle_tmr.sv
// Purpose: Settling timer that counts a fixed interval after a start.
// Assumes: Start is a one-cycle pulse; a new start restarts the count.
// Notes: Expired rises CYC edges after the start edge and then holds.
`timescale 1ns/100ps
module rbs_settle_tmr import rbs_pkg::*; #(
    parameter int CYC = SETTLE_CYC
) (
    input wire logic core_clk, // Core clock.
    input wire logic rst, // Asynchronous reset, active high.
    rbs_ctl_if.tmr ctl // Start pulse in, expired level out.
);
    logic [TMR_W-1:0] count;
    logic running;
    logic expired;

    assign ctl.tmr_expired = expired;

    // Count down; a start always wins so a restart is never missed.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (ctl.tmr_start) begin
            count <= TMR_W'(CYC - 1);
            running <= 1'b1;
            expired <= 1'b0;
        end else if (running) begin
            if (count == '0) begin
                running <= 1'b0;
                expired <= 1'b1;
            end else begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ### src/rbs_clk_gate.sv
// Purpose: Holds the peripheral clock gate vector.
// Assumes: Only one peripheral is ungated at a time.
// Notes: A set bit means that peripheral clock is off.
`timescale 1ns/100ps
module rbs_clk_gate import rbs_pkg::*; (
    input wire logic core_clk, // Core clock.
    input wire logic rst, // Asynchronous reset, active high.
    rbs_ctl_if.gate ctl, // Select and enable from the sequencer.
    output logic [PCLK_W-1:0] gate_off // Clock off per peripheral.
);
    // All clocks start off to save power; one opens while queried and stays open through configuration and load.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_off <= PCLK_ALL_OFF;
        end else if (ctl.gate_on) begin
            gate_off <= ~(PCLK_W'(1) << ctl.gate_sel);
        end else begin
            gate_off <= PCLK_ALL_OFF;
        end
    end
endmodule

// ### src/rbs_boot_seq.sv
// Purpose: Boot sequencer run after every reset: clocks, PLL, source
//          probing in priority order, configuration, load and jump.
// Assumes: Probe, configuration and load engines outside answer with
//          one-cycle done pulses; the clock select strap is static.
// Notes: The USB probe repeats forever once every other source fails.
`timescale 1ns/100ps
module rbs_boot_seq import rbs_pkg::*; #(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic core_clk, // Core clock, 25 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic clk_sel_strap, // Clock select strap level.
    input wire logic probe_done, // Probe engine finished, pulse.
    input wire logic probe_sig_ok, // Signature matched, with done.
    input wire logic cfg_present, // Image has a register section.
    input wire logic cfg_done, // Register section applied, pulse.
    input wire logic load_done, // Image loaded, pulse.
    input wire logic [23:0] image_entry, // Entry point, with load_done.
    output logic [23:0] fetch_addr, // Processor reset vector.
    output logic memory_map_select, // Zero maps the vector to ROM.
    output logic clock_output_slow_slew, // Slow slew on clock pin.
    output logic clock_output_enable, // Clock output pin enable.
    output logic [3:0] idle_domain_control, // Idle request per domain.
    output logic pll_powered, // PLL power up.
    output logic pll_bypass, // PLL bypassed, input drives clock.
    output logic [11:0] pll_multiplier_value, // PLL multiplier.
    output logic [1:0] pll_multiplier_fraction, // Multiplier fraction.
    output logic pll_in_div_en, // PLL input divider enable.
    output logic pll_out_div8_en, // PLL output divide by 8.
    output logic pll_out_div_en, // PLL output divider enable.
    output logic [4:0] pll_output_divider_value, // Output divider.
    output logic bandgap_trim_apply, // Apply trim, pulse.
    output logic [PCLK_W-1:0] periph_clk_gate, // Set bit: clock off.
    output logic probe_req, // Start a probe, pulse.
    output logic [2:0] probe_source, // Source being probed.
    output logic [4:0] probe_access_bits, // Parallel access width.
    output logic probe_addr24, // SPI 24-bit addressing.
    output logic [2:0] probe_bus_mode, // External bus selection.
    output logic [1:0] probe_spi_cs, // SPI chip select used.
    output logic [6:0] probe_i2c_addr, // I2C target address.
    output logic cfg_req, // Apply register section, pulse.
    output logic load_req, // Load the image, pulse.
    output logic settling_timer_run, // Settling timer counting.
    output logic [23:0] jump_addr, // Entry point to jump to.
    output logic jump_req, // Jump to user code, pulse.
    output logic boot_done, // Control handed to user code.
    output logic ram_block31_reserved // Scratch block held by boot.
);
    typedef enum logic [13:0] {
        ST_START = 14'h0001,
        ST_SLEW = 14'h0002,
        ST_IDLE = 14'h0004,
        ST_PLL = 14'h0008,
        ST_TRIM = 14'h0010,
        ST_CKOFF = 14'h0020,
        ST_PROBE = 14'h0040,
        ST_WAIT = 14'h0080,
        ST_CFG = 14'h0100,
        ST_LOAD = 14'h0200,
        ST_SETTLE = 14'h0400,
        ST_JUMP = 14'h0800,
        ST_USBPLL = 14'h1000,
        ST_RUN = 14'h2000
    } rbs_state_t;

    rbs_state_t state;
    rbs_state_t next_state;
    logic [3:0] step;
    logic strap;
    logic [2:0] step_src;
    logic [2:0] step_pclk;
    logic step_a24;
    logic [2:0] step_mode;
    logic [4:0] step_bits;
    logic gate_on;
    logic tmr_start;
    rbs_ctl_if ctl();

    assign ctl.gate_sel = step_pclk;
    assign ctl.gate_on = gate_on;
    assign ctl.tmr_start = tmr_start;

    rbs_clk_gate u_gate (
        .core_clk(core_clk),
        .rst(rst),
        .ctl(ctl.gate),
        .gate_off(periph_clk_gate)
    );

    rbs_settle_tmr #(.CYC(SETTLE_CYCLES)) u_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .ctl(ctl.tmr)
    );

    // Map each probe step onto its source, peripheral and options.
    always_comb begin
        step_src = SRC_USB;
        step_pclk = PCLK_USB;
        step_a24 = 1'b0;
        step_mode = BUS_MODE_A;
        step_bits = NOR_ACCESS_BITS;
        case (step)
            4'h0: begin
                step_src = SRC_NOR;
                step_pclk = PCLK_EMIF;
            end
            4'h1: begin
                step_src = SRC_NAND;
                step_pclk = PCLK_EMIF;
                step_bits = NAND_ACCESS_BITS;
            end
            4'h2, 4'h3, 4'h4, 4'h5: begin
                step_src = SRC_SPI;
                step_pclk = PCLK_SPI;
                step_a24 = step[0];
                step_mode = step[2] ? BUS_MODE_B : BUS_MODE_A;
            end
            4'h6: begin
                step_src = SRC_I2C;
                step_pclk = PCLK_I2C;
            end
            4'h7: begin
                step_src = SRC_MMC;
                step_pclk = PCLK_MMC;
            end
            default: begin
                step_src = SRC_USB;
                step_pclk = PCLK_USB;
            end
        endcase
    end

    // Sequence steps; only reset or an illegal state code re-enters the start state.
    always_comb begin
        next_state = state;
        case (state)
            ST_START: next_state = ST_SLEW;
            ST_SLEW: next_state = ST_IDLE;
            ST_IDLE: next_state = ST_PLL;
            ST_PLL: next_state = ST_TRIM;
            ST_TRIM: next_state = ST_CKOFF;
            ST_CKOFF: next_state = ST_PROBE;
            ST_PROBE: next_state = ST_WAIT;
            ST_WAIT: begin
                if (probe_done && probe_sig_ok) begin
                    next_state = cfg_present ? ST_CFG : ST_LOAD;
                end else if (probe_done && step == STEP_LAST_SCAN) begin
                    next_state = ST_USBPLL;
                end else if (probe_done) begin
                    next_state = ST_PROBE;
                end
            end
            ST_CFG: if (cfg_done) next_state = ST_LOAD;
            ST_LOAD: if (load_done) next_state = ST_SETTLE;
            ST_SETTLE: if (ctl.tmr_expired) next_state = ST_JUMP;
            ST_JUMP: next_state = ST_RUN;
            ST_USBPLL: next_state = ST_PROBE;
            ST_RUN: next_state = ST_RUN;
            default: next_state = ST_START;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_START;
        end else begin
            state <= next_state;
        end
    end

    // Strap is caught once after reset release; it must not move later.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap <= 1'b0;
        end else if (state == ST_START) begin
            strap <= clk_sel_strap;
        end
    end

    // Step advances only on a failed signature, in fixed priority.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step <= STEP_FIRST;
        end else if (state == ST_WAIT && probe_done && !probe_sig_ok) begin
            if (step == STEP_LAST_SCAN || step == STEP_USB) begin
                step <= STEP_USB;
            end else begin
                step <= step + 1'b1;
            end
        end
    end

    // Vector and map select are fixed values from reset onward.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetch_addr <= RESET_VECTOR;
            memory_map_select <= MEM_MAP_SEL_RST;
        end else begin
            fetch_addr <= RESET_VECTOR;
            memory_map_select <= MEM_MAP_SEL_RST;
        end
    end

    // PLL programming for the scan when the strap is low (bypass kept when high), and for the USB phase.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pll_powered <= 1'b0;
            pll_bypass <= 1'b1;
            pll_multiplier_value <= PLL_MULT_RST;
            pll_multiplier_fraction <= PLL_FRAC_BOOT;
            pll_in_div_en <= 1'b0;
            pll_out_div8_en <= 1'b0;
            pll_out_div_en <= 1'b0;
            pll_output_divider_value <= PLL_OUT_DIV_BOOT;
        end else if (state == ST_PLL && !strap) begin
            pll_powered <= 1'b1;
            pll_bypass <= 1'b0;
            pll_multiplier_value <= PLL_MULT_375X;
            pll_multiplier_fraction <= PLL_FRAC_BOOT;
            pll_in_div_en <= 1'b0;
            pll_out_div8_en <= 1'b1;
            pll_out_div_en <= 1'b1;
            pll_output_divider_value <= PLL_OUT_DIV_BOOT;
        end else if (state == ST_PLL) begin
            pll_bypass <= 1'b1;
        end else if (state == ST_USBPLL) begin
            pll_powered <= 1'b1;
            pll_bypass <= 1'b0;
            pll_multiplier_value <= strap ? PLL_MULT_3X
                                          : PLL_MULT_1125X;
            pll_out_div8_en <= 1'b0;
            pll_out_div_en <= 1'b0;
        end
    end

    // Clock pin, trim pulse and idle requests.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clock_output_slow_slew <= 1'b0;
            clock_output_enable <= CLOCK_OUTPUT_PIN_EN_RST;
            idle_domain_control <= IDLE_NONE;
            bandgap_trim_apply <= 1'b0;
        end else begin
            bandgap_trim_apply <= (state == ST_TRIM);
            if (state == ST_SLEW) begin
                clock_output_slow_slew <= 1'b1;
            end
            if (state == ST_IDLE || state == ST_SETTLE) begin
                idle_domain_control <= IDLE_ALL_BUT_CPU;
            end
            if (state == ST_CKOFF) begin
                clock_output_enable <= 1'b0;
            end
        end
    end

    // Probe request and its options, issued on the same edge that ungates the clock.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_on <= 1'b0;
            probe_req <= 1'b0;
            probe_source <= SRC_NOR;
            probe_access_bits <= NOR_ACCESS_BITS;
            probe_addr24 <= 1'b0;
            probe_bus_mode <= BUS_MODE_A;
            probe_spi_cs <= SPI_CHIP_SELECT;
            probe_i2c_addr <= I2C_TARGET_ADDR;
        end else begin
            probe_req <= (state == ST_PROBE);
            if (next_state == ST_PROBE) begin
                gate_on <= 1'b1;
            end else if (state == ST_WAIT && probe_done && !probe_sig_ok) begin
                gate_on <= 1'b0;
            end else if (state == ST_LOAD && load_done) begin
                gate_on <= 1'b0;
            end
            if (state == ST_PROBE) begin
                probe_source <= step_src;
                probe_access_bits <= step_bits;
                probe_addr24 <= step_a24;
                probe_bus_mode <= step_mode;
            end
        end
    end

    // Configuration and load requests after a valid signature.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_req <= 1'b0;
            load_req <= 1'b0;
        end else begin
            cfg_req <= (next_state == ST_CFG && state != ST_CFG);
            load_req <= (next_state == ST_LOAD && state != ST_LOAD);
        end
    end

    // Handoff: timer start on load, jump once the interval has passed.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tmr_start <= 1'b0;
            settling_timer_run <= 1'b0;
            jump_addr <= '0;
            jump_req <= 1'b0;
            boot_done <= 1'b0;
            ram_block31_reserved <= 1'b1;
        end else begin
            tmr_start <= (state == ST_LOAD && load_done);
            jump_req <= (state == ST_JUMP);
            if (state == ST_LOAD && load_done) begin
                jump_addr <= image_entry;
                settling_timer_run <= 1'b1;
            end
            if (state == ST_JUMP) begin
                settling_timer_run <= 1'b0;
                boot_done <= 1'b1;
                ram_block31_reserved <= 1'b0;
            end
        end
    end
endmodule

// ### testbench/rbs_boot_seq_props.sv
// Purpose: Port checks on the boot sequencer.
// Assumes: Engines answer only while a probe or request is pending.
// Notes: Bound into every sequencer instance.
`timescale 1ns/100ps
module rbs_boot_seq_props import rbs_pkg::*; #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic core_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic clk_sel_strap, // Strap.
    input wire logic probe_done, // In.
    input wire logic probe_sig_ok, // In.
    input wire logic cfg_present, // In.
    input wire logic clock_output_slow_slew, // Out.
    input wire logic clock_output_enable, // Out.
    input wire logic [3:0] idle_domain_control, // Out.
    input wire logic pll_bypass, // Out.
    input wire logic [11:0] pll_multiplier_value, // Out.
    input wire logic [PCLK_W-1:0] periph_clk_gate, // Out.
    input wire logic probe_req, // Out.
    input wire logic [2:0] probe_source, // Out.
    input wire logic [4:0] probe_access_bits, // Out.
    input wire logic cfg_req, // Out.
    input wire logic load_req, // Out.
    input wire logic settling_timer_run, // Out.
    input wire logic jump_req, // Out.
    input wire logic boot_done, // Out.
    input wire logic ram_block31_reserved // Out.
);
    // Start pulse, count down, expiry and state step sit between them.
    localparam int JUMP_DLY = SETTLE_CYCLES + 3;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Reset state and the preparation done before any probe.
    property p_reset_state;
        $fell(rst) |-> periph_clk_gate == 8'hFF && idle_domain_control == 4'h0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset bad");
    property p_one_gate;
        probe_req |-> $onehot(~periph_clk_gate);
    endproperty
    a_one_gate: assert property (p_one_gate) else $error("gate bad");
    property p_prep;
        probe_req |-> clock_output_slow_slew && !clock_output_enable
            && idle_domain_control == 4'hE;
    endproperty
    a_prep: assert property (p_prep) else $error("prep bad");
    // Probe options and clock settings seen with each probe request.
    property p_width;
        probe_req && probe_source < 3'h2 |->
            probe_access_bits == (probe_source == 3'h0 ? 5'h10 : 5'h08);
    endproperty
    a_width: assert property (p_width) else $error("width bad");
    property p_pll_boot;
        probe_req && probe_source != 3'h5 |-> (clk_sel_strap ? pll_bypass
            : !pll_bypass && pll_multiplier_value == 12'h2ED);
    endproperty
    a_pll_boot: assert property (p_pll_boot) else $error("pll bad");
    property p_pll_usb;
        probe_req && probe_source == 3'h5 |-> !pll_bypass
            && pll_multiplier_value == (clk_sel_strap ? 12'h005 : 12'h8C9);
    endproperty
    a_pll_usb: assert property (p_pll_usb) else $error("usb pll bad");
    // A good signature leads to configuration when a register section is present, else straight to loading.
    property p_cfg_first;
        probe_done && probe_sig_ok |=> cfg_req == $past(cfg_present)
            && load_req == !$past(cfg_present);
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("cfg bad");
    property p_handoff;
        $rose(settling_timer_run) |-> ##JUMP_DLY jump_req && boot_done
            && periph_clk_gate == 8'hFF && idle_domain_control == 4'hE
            && !ram_block31_reserved;
    endproperty
    a_handoff: assert property (p_handoff) else $error("jump bad");
endmodule

bind rbs_boot_seq rbs_boot_seq_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
    .core_clk, .rst, .clk_sel_strap, .probe_done, .probe_sig_ok, .cfg_present,
    .clock_output_slow_slew, .clock_output_enable, .idle_domain_control,
    .pll_bypass, .pll_multiplier_value, .periph_clk_gate, .probe_req,
    .probe_source, .probe_access_bits, .cfg_req, .load_req,
    .settling_timer_run, .jump_req, .boot_done, .ram_block31_reserved);

// ### testbench/rbs_mem_model.sv
// Purpose: Boot memories answering probe, config and load requests.
// Assumes: Requests never overlap; answers move at the falling edge.
// Notes: Only probe number win sees a good signature.
`timescale 1ns/100ps
module rbs_mem_model (
    input wire logic core_clk, // Core clock.
    input wire logic rst, // Reset, active high.
    input wire logic probe_req, // Probe start.
    input wire logic cfg_req, // Config start.
    input wire logic load_req, // Load start.
    input wire logic [4:0] win, // Winning probe index.
    input wire logic want_cfg, // Image holds a register section.
    input wire logic [1:0] dly, // Answer delay in cycles.
    output logic probe_done, // Probe answer pulse.
    output logic probe_sig_ok, // Signature good.
    output logic cfg_present, // Register section flag.
    output logic cfg_done, // Config applied pulse.
    output logic load_done, // Load finished pulse.
    output logic [23:0] image_entry // Entry point.
);
    logic [4:0] cnt;
    logic [1:0] kind;
    logic [1:0] wt;
    logic hit;
    // Flags show their inverse outside the pulse, so stale copies fail.
    assign probe_sig_ok = probe_done ? hit : !hit;
    assign cfg_present = probe_done ? want_cfg : !want_cfg;
    assign image_entry = load_done ? {19'h2A5C3, win} : ~{19'h2A5C3, win};
    // One pending request; it answers after dly idle cycles.
    always @(negedge core_clk or posedge rst) begin
        probe_done = 1'b0;
        cfg_done = 1'b0;
        load_done = 1'b0;
        if (rst) begin
            cnt = 5'h00;
            kind = 2'h0;
            hit = 1'b0;
        end else if (probe_req || cfg_req || load_req) begin
            kind = probe_req ? 2'h1 : (cfg_req ? 2'h2 : 2'h3);
            wt = dly;
        end else if (kind != 2'h0 && wt != 2'h0) begin
            wt = wt - 2'h1;
        end else if (kind != 2'h0) begin
            probe_done = (kind == 2'h1);
            cfg_done = (kind == 2'h2);
            load_done = (kind == 2'h3);
            hit = (cnt == win);
            cnt = cnt + {4'h0, kind == 2'h1};
            kind = 2'h0;
        end
    end
endmodule

// ### testbench/tb.sv
// Purpose: Boots the sequencer against every source, strap and delay.
// Assumes: Inputs move at the falling edge.
// Notes: Settling count is shortened so the run stays brief.
`timescale 1ns/100ps
module tb import rbs_pkg::*;;
    localparam int SETTLE = 20;
    logic core_clk = 1'b0, rst = 1'b1, clk_sel_strap = 1'b0;
    logic want_cfg = 1'b0;
    logic [4:0] win = 5'h00;
    logic [1:0] dly = 2'h0;
    logic probe_done, probe_sig_ok, cfg_present, cfg_done, load_done;
    logic memory_map_select, clock_output_slow_slew, clock_output_enable;
    logic pll_powered, pll_bypass, pll_in_div_en, pll_out_div8_en;
    logic pll_out_div_en, bandgap_trim_apply, probe_req, probe_addr24;
    logic cfg_req, load_req, settling_timer_run, jump_req, boot_done;
    logic ram_block31_reserved;
    logic [23:0] image_entry, fetch_addr, jump_addr;
    logic [3:0] idle_domain_control;
    logic [11:0] pll_multiplier_value;
    logic [1:0] pll_multiplier_fraction, probe_spi_cs;
    logic [4:0] pll_output_divider_value, probe_access_bits;
    logic [7:0] periph_clk_gate;
    logic [2:0] probe_source, probe_bus_mode;
    logic [6:0] probe_i2c_addr;
    logic [6:0] log_q[$];
    int errors = 0, num_checks = 0, cyc = 0, t_load = 0, t_jump = 0;

    rbs_boot_seq #(.SETTLE_CYCLES(SETTLE)) dut (.core_clk, .rst,
        .clk_sel_strap, .probe_done, .probe_sig_ok, .cfg_present, .cfg_done,
        .load_done, .image_entry, .fetch_addr, .memory_map_select,
        .clock_output_slow_slew, .clock_output_enable, .idle_domain_control,
        .pll_powered, .pll_bypass, .pll_multiplier_value,
        .pll_multiplier_fraction, .pll_in_div_en, .pll_out_div8_en,
        .pll_out_div_en, .pll_output_divider_value, .bandgap_trim_apply,
        .periph_clk_gate, .probe_req, .probe_source, .probe_access_bits,
        .probe_addr24, .probe_bus_mode, .probe_spi_cs, .probe_i2c_addr,
        .cfg_req, .load_req, .jump_addr, .settling_timer_run, .jump_req,
        .boot_done, .ram_block31_reserved);
    rbs_mem_model mem (.core_clk, .rst, .probe_req, .cfg_req, .load_req,
        .win, .want_cfg, .dly, .probe_done, .probe_sig_ok, .cfg_present,
        .cfg_done, .load_done, .image_entry);

    always #20 core_clk = ~core_clk;
    // Probe log, event times and cycle limit.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (probe_req) log_q.push_back({probe_source, probe_addr24, probe_bus_mode});
        if (load_done) t_load <= cyc;
        if (jump_req) t_jump <= cyc;
        if (cyc == 4000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [23:0] exp, got);
        num_checks++;
        if (exp !== got) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One boot; probe number w wins, w of 9 leaves only the USB loop.
    task automatic run(input logic strap, input int w, input logic c);
        int n;
        logic [6:0] e;
        rst = 1'b1;
        clk_sel_strap = strap;
        win = w < 9 ? w[4:0] : 5'h1F;
        want_cfg = c;
        dly = w[1:0];
        repeat (5) @(negedge core_clk);
        check("gate_rst", 24'hFF, {16'h0, periph_clk_gate});
        check("vector", 24'hFFFF00, fetch_addr);
        check("rom_bypass", 24'h1, {22'h0, memory_map_select, pll_bypass});
        log_q.delete();
        rst = 1'b0;
        n = 0;
        while (boot_done !== 1'b1 && log_q.size() < 12 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        // Let the jump edge reach the event log before it is read.
        @(negedge core_clk);
        check("probes", 24'(w < 9 ? w + 1 : 12), 24'(log_q.size()));
        foreach (log_q[i]) begin
            e[6:4] = i < 2 ? 3'(i) : (i < 6 ? 3'h2 : (i < 8 ? 3'(i - 3) : 3'h5));
            e[3] = (i == 3 || i == 5);
            e[2:0] = (i < 2 || i > 5) ? log_q[i][2:0] : (i < 4 ? 3'h5 : 3'h6);
            check("step", 24'(e), 24'(log_q[i]));
        end
        check("serial", 24'h50, {15'h0, probe_spi_cs, probe_i2c_addr});
        check("pll", w < 8 ? (strap ? 24'h1 : 24'h2ED) : (strap ? 24'h5 : 24'h8C9),
            (strap && w < 8) ? 24'(pll_bypass) : 24'(pll_multiplier_value));
        if (w < 9) begin
            check("settle", 24'(SETTLE + 4), 24'(t_jump - t_load));
            check("entry", {19'h2A5C3, win}, jump_addr);
            check("handoff", 24'hEFF, {12'h0, idle_domain_control,
                periph_clk_gate});
            check("scratch", 24'h0, {23'h0, ram_block31_reserved});
        end
        $display("test strap %0b win %0d cfg %0b done", strap, w, c);
    endtask

    // Each probe step wins once, then none; reset restarts.
    initial begin
        for (int w = 0; w < 10; w++) run(w[0], w, w[1]);
        run(1'b0, 9, 1'b0);
        print_verdict();
    end
endmodule
